// ### hw/pcps_pkg.sv
// Purpose: constants and types of the phase calibration and sign block
// Assumes: register indices are word indices on AHB-Lite (byte = 4*index)
// Notes: power samples are signed two's complement words
package pcps_pkg;

  // Word width of one power sample
  localparam int PWR_W = 24;

  // Register indices
  localparam logic [15:0] IDX_PHASE_A_COMP = 16'hE614;
  localparam logic [15:0] IDX_PHASE_B_COMP = 16'hE615;
  localparam logic [15:0] IDX_PHASE_C_COMP = 16'hE616;
  localparam logic [15:0] IDX_SIGN_STATUS = 16'hE617;
  localparam logic [15:0] IDX_SIGN_SOURCE = 16'hE620;
  localparam logic [15:0] IDX_PULSE_INCLUDE = 16'hE621;
  localparam logic [15:0] IDX_PULSE_TYPE = 16'hE622;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hE623;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hE624;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'hE625;

  // Compensation register fields
  localparam int COMP_VAL_W = 10;
  localparam int COMP_VOLT_BIT = 9;
  localparam int COMP_AMT_W = 9;
  localparam logic [8:0] COMP_ALIAS_LO = 9'h180;
  localparam logic [15:0] COMP_RST = 16'h0000;

  // Sign status field positions
  localparam int SIGN_W = 9;
  localparam int POS_ACT_NEG = 0;
  localparam int POS_SUM1_NEG = 3;
  localparam int POS_REACT_NEG = 4;
  localparam int POS_SUM2_NEG = 7;
  localparam int POS_SUM3_NEG = 8;
  localparam logic [8:0] SIGN_RST = 9'h000;

  // Sign source select fields
  localparam int SRC_ACT_BIT = 0;
  localparam int SRC_REACT_BIT = 1;
  localparam logic [1:0] SRC_RST = 2'h0;

  // Pulse datapath fields, three bits per datapath
  localparam int PULSE_FLD_W = 3;
  localparam logic [8:0] INCLUDE_RST = 9'h1FF;
  localparam logic [8:0] PTYPE_RST = 9'h088;

  // Interrupt enable reset
  localparam logic [8:0] IRQ_EN_RST = 9'h000;

  // AHB-Lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Power type of a pulse datapath
  typedef enum logic [2:0] {
    PT_TOT_ACT = 3'b000,
    PT_TOT_REACT = 3'b001,
    PT_APPARENT = 3'b010,
    PT_FUND_ACT = 3'b011,
    PT_FUND_REACT = 3'b100
  } pcps_ptype_e;

  // One phase's computed powers
  typedef struct packed {
    logic signed [PWR_W-1:0] tot_act;
    logic signed [PWR_W-1:0] fund_act;
    logic signed [PWR_W-1:0] tot_react;
    logic signed [PWR_W-1:0] fund_react;
    logic signed [PWR_W-1:0] apparent;
  } pcps_phase_power_s;

endpackage

// ### hw/pcps_regs.sv
// Purpose: phase compensation registers and power sign status over AHB-Lite
// Assumes: power samples arrive with a one-cycle power_update strobe
// Notes: zero wait state slave, reads registered in the address phase
//
// Overview of operation
// - Compensation codes 0 to 383 select current-channel compensation.
// - Codes 512 to 895 compensate the voltage channel instead.
// - Codes 384 to 511 act like codes 0 to 127.
// - Codes 896 to 1023 act like codes 512 to 639.
// - Compensation bits 15 to 10 read zero and do nothing.
// - Status bits 0-2 flag negative active power, total or fundamental.
// - Status bits 4-6 flag negative reactive power, total or fundamental.
// - Status bit 3 flags a negative sum in pulse datapath one.
// - Status bit 7 flags a negative sum in pulse datapath two.
// - Status bit 8 flags a negative sum in pulse datapath three.
// - Each sum uses its included phases and its chosen power type.
// - Sign status bits 15 to 9 always read zero.
// - Power types 000 to 100 valid; 101 to 111 suppress the output.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module pcps_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power samples from the datapath
  input wire logic power_update,
  input wire pcps_pkg::pcps_phase_power_s [2:0] phase_power,
  // Decoded compensation per phase
  output logic [2:0] comp_voltage_sel,
  output logic [2:0][pcps_pkg::COMP_AMT_W-1:0] comp_amount,
  // Pulse datapath enables
  output logic [2:0] pulse_type_valid,
  // Interrupt
  output logic irq
);

  logic [2:0][15:0] phcomp;
  logic [pcps_pkg::SIGN_W-1:0] sign;
  logic [pcps_pkg::SIGN_W-1:0] next_sign;
  logic [1:0] sign_src;
  logic [8:0] pulse_include;
  logic [8:0] pulse_type;
  logic [pcps_pkg::SIGN_W-1:0] irq_status;
  logic [pcps_pkg::SIGN_W-1:0] irq_enable;
  logic [pcps_pkg::SIGN_W-1:0] irq_clr;
  logic [pcps_pkg::SIGN_W-1:0] irq_set;
  logic [2:0] sum_neg;
  logic a_take;
  logic addr_ok;
  logic [15:0] a_idx;
  logic wr_pend;
  logic [15:0] wr_idx;
  logic [31:0] rd_word;

  // Address phase decode; byte writes are ignored, word access only
  assign a_take = hsel & htrans[1] & hready;
  assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0) &&
                   (hsize == pcps_pkg::HSIZE_WORD);
  assign a_idx = addr_ok ? haddr[17:2] : 16'h0000;

  // Selects one power of a phase by datapath type
  function automatic logic signed [pcps_pkg::PWR_W-1:0] pick(
    input pcps_pkg::pcps_phase_power_s p,
    input logic [2:0] t
  );
    case (t)
      pcps_pkg::PT_TOT_ACT: pick = p.tot_act;
      pcps_pkg::PT_TOT_REACT: pick = p.tot_react;
      pcps_pkg::PT_APPARENT: pick = p.apparent;
      pcps_pkg::PT_FUND_ACT: pick = p.fund_act;
      pcps_pkg::PT_FUND_REACT: pick = p.fund_react;
      default: pick = '0;
    endcase
  endfunction

  // Writable bits of each stored register; read-only ones and the write-only IRQ clear give zero
  function automatic logic [31:0] wr_mask(input logic [15:0] idx);
    case (idx)
      pcps_pkg::IDX_PHASE_A_COMP,
      pcps_pkg::IDX_PHASE_B_COMP,
      pcps_pkg::IDX_PHASE_C_COMP: wr_mask = 32'h000003FF;
      pcps_pkg::IDX_SIGN_SOURCE: wr_mask = 32'h00000003;
      pcps_pkg::IDX_PULSE_INCLUDE,
      pcps_pkg::IDX_PULSE_TYPE,
      pcps_pkg::IDX_IRQ_ENABLE: wr_mask = 32'h000001FF;
      default: wr_mask = 32'h00000000;
    endcase
  endfunction

  // Sign of each phase power and of each pulse datapath sum
  always_comb begin
    logic signed [pcps_pkg::PWR_W+1:0] sum;
    logic [2:0] t;
    sum = '0;
    t = 3'h0;
    next_sign = sign;
    for (int p = 0; p < 3; p++) begin
      next_sign[pcps_pkg::POS_ACT_NEG+p] = sign_src[pcps_pkg::SRC_ACT_BIT]
        ? phase_power[p].fund_act[pcps_pkg::PWR_W-1]
        : phase_power[p].tot_act[pcps_pkg::PWR_W-1];
      next_sign[pcps_pkg::POS_REACT_NEG+p] = sign_src[pcps_pkg::SRC_REACT_BIT]
        ? phase_power[p].fund_react[pcps_pkg::PWR_W-1]
        : phase_power[p].tot_react[pcps_pkg::PWR_W-1];
    end
    for (int k = 0; k < 3; k++) begin
      sum = '0;
      t = pulse_type[pcps_pkg::PULSE_FLD_W*k +: pcps_pkg::PULSE_FLD_W];
      for (int p = 0; p < 3; p++) begin
        if (pulse_include[pcps_pkg::PULSE_FLD_W*k+p]) begin
          sum = sum + (pcps_pkg::PWR_W+2)'(pick(phase_power[p], t));
        end
      end
      sum_neg[k] = sum[pcps_pkg::PWR_W+1];
    end
    next_sign[pcps_pkg::POS_SUM1_NEG] = sum_neg[0];
    next_sign[pcps_pkg::POS_SUM2_NEG] = sum_neg[1];
    next_sign[pcps_pkg::POS_SUM3_NEG] = sum_neg[2];
  end

  // Read mux; a write still in its data phase is forwarded
  always_comb begin
    rd_word = 32'h00000000;
    case (a_idx)
      pcps_pkg::IDX_PHASE_A_COMP: rd_word = {16'h0000, phcomp[0]};
      pcps_pkg::IDX_PHASE_B_COMP: rd_word = {16'h0000, phcomp[1]};
      pcps_pkg::IDX_PHASE_C_COMP: rd_word = {16'h0000, phcomp[2]};
      pcps_pkg::IDX_SIGN_STATUS: rd_word = {23'h000000, sign};
      pcps_pkg::IDX_SIGN_SOURCE: rd_word = {30'h00000000, sign_src};
      pcps_pkg::IDX_PULSE_INCLUDE: rd_word = {23'h000000, pulse_include};
      pcps_pkg::IDX_PULSE_TYPE: rd_word = {23'h000000, pulse_type};
      pcps_pkg::IDX_IRQ_STATUS: rd_word = {23'h000000, irq_status};
      pcps_pkg::IDX_IRQ_ENABLE: rd_word = {23'h000000, irq_enable};
      default: rd_word = 32'h00000000;
    endcase
    if (wr_pend && (wr_idx == a_idx) && (wr_mask(a_idx) != 32'h0)) begin
      rd_word = hwdata & wr_mask(a_idx);
    end
  end

  // Bus data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
    end else begin
      wr_pend <= a_take & hwrite;
      wr_idx <= a_idx;
    end
  end

  // Bus answer; never stalls, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= pcps_pkg::HRESP_OKAY;
    end else begin
      hrdata <= (a_take && !hwrite) ? rd_word : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= pcps_pkg::HRESP_OKAY;
    end
  end

  // Compensation registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phcomp <= {3{pcps_pkg::COMP_RST}};
    end else if (wr_pend) begin
      for (int p = 0; p < 3; p++) begin
        if (wr_idx == pcps_pkg::IDX_PHASE_A_COMP + 16'(p)) begin
          phcomp[p] <= {6'h00, hwdata[pcps_pkg::COMP_VAL_W-1:0]};
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sign_src <= pcps_pkg::SRC_RST;
      pulse_include <= pcps_pkg::INCLUDE_RST;
      pulse_type <= pcps_pkg::PTYPE_RST;
      irq_enable <= pcps_pkg::IRQ_EN_RST;
    end else if (wr_pend) begin
      case (wr_idx)
        pcps_pkg::IDX_SIGN_SOURCE: sign_src <= hwdata[1:0];
        pcps_pkg::IDX_PULSE_INCLUDE: pulse_include <= hwdata[8:0];
        pcps_pkg::IDX_PULSE_TYPE: pulse_type <= hwdata[8:0];
        pcps_pkg::IDX_IRQ_ENABLE: irq_enable <= hwdata[8:0];
        default: ;
      endcase
    end
  end

  // Sign status follows each new sample; bus writes never reach it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sign <= pcps_pkg::SIGN_RST;
    end else if (power_update) begin
      sign <= next_sign;
    end
  end

  // Sign changes are the interrupt events; set beats clear
  assign irq_set = power_update ? (next_sign ^ sign) : '0;
  assign irq_clr = (wr_pend && (wr_idx == pcps_pkg::IDX_IRQ_CLEAR))
                   ? hwdata[pcps_pkg::SIGN_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      irq <= |(irq_status & irq_enable);
    end
  end

  // Compensation decode; codes whose bits 8 to 0 are at or above the alias point fold back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_voltage_sel <= 3'h0;
      comp_amount <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        comp_voltage_sel[p] <= phcomp[p][pcps_pkg::COMP_VOLT_BIT];
        if (phcomp[p][8:0] >= pcps_pkg::COMP_ALIAS_LO) begin
          comp_amount[p] <= phcomp[p][8:0] - pcps_pkg::COMP_ALIAS_LO;
        end else begin
          comp_amount[p] <= phcomp[p][8:0];
        end
      end
    end
  end

  // Pulse datapath enable from its power type
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_type_valid <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        pulse_type_valid[k] <=
          pulse_type[pcps_pkg::PULSE_FLD_W*k +: pcps_pkg::PULSE_FLD_W]
          <= pcps_pkg::PT_FUND_REACT;
      end
    end
  end

  // Checks
  logic [9:0] code_a;
  logic rd_sign;
  logic wr_comp_a;
  assign code_a = phcomp[0][9:0];
  assign rd_sign = a_take && !hwrite && (a_idx == pcps_pkg::IDX_SIGN_STATUS);
  assign wr_comp_a = wr_pend && (wr_idx == pcps_pkg::IDX_PHASE_A_COMP);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_cur_range;
    (code_a < 10'h180) |=>
      !comp_voltage_sel[0] && (comp_amount[0] == $past(code_a[8:0]));
  endproperty
  a_cur_range: assert property (p_cur_range)
    else $error("current range code misdecoded");

  property p_volt_range;
    (code_a >= 10'h200) && (code_a < 10'h380) |=>
      comp_voltage_sel[0] && (comp_amount[0] == $past(code_a[8:0]));
  endproperty
  a_volt_range: assert property (p_volt_range)
    else $error("voltage range code misdecoded");

  property p_cur_alias;
    (code_a >= 10'h180) && (code_a < 10'h200) |=>
      !comp_voltage_sel[0] &&
      (comp_amount[0] == $past(code_a[8:0]) - 9'h180);
  endproperty
  a_cur_alias: assert property (p_cur_alias)
    else $error("current alias code misdecoded");

  property p_volt_alias;
    (code_a >= 10'h380) |=>
      comp_voltage_sel[0] &&
      (comp_amount[0] == $past(code_a[8:0]) - 9'h180);
  endproperty
  a_volt_alias: assert property (p_volt_alias)
    else $error("voltage alias code misdecoded");

  property p_comp_write;
    wr_comp_a |=> (phcomp[0] == {6'h00, $past(hwdata[9:0])});
  endproperty
  a_comp_write: assert property (p_comp_write)
    else $error("compensation write wrong or reserved bits set");

  property p_act_sign;
    power_update && !sign_src[0] |=>
      (sign[0] == $past(phase_power[0].tot_act[23]));
  endproperty
  a_act_sign: assert property (p_act_sign)
    else $error("phase A active sign wrong");

  property p_react_sign;
    power_update && sign_src[1] |=>
      (sign[6] == $past(phase_power[2].fund_react[23]));
  endproperty
  a_react_sign: assert property (p_react_sign)
    else $error("phase C reactive sign wrong");

  property p_sum1_single;
    power_update && (pulse_include[2:0] == 3'b010) &&
      (pulse_type[2:0] == 3'b000) |=>
      (sign[3] == $past(phase_power[1].tot_act[23]));
  endproperty
  a_sum1_single: assert property (p_sum1_single)
    else $error("datapath one sum sign wrong");

  property p_sum2_empty;
    power_update && (pulse_include[5:3] == 3'b000) |=> !sign[7];
  endproperty
  a_sum2_empty: assert property (p_sum2_empty)
    else $error("datapath two empty sum not positive");

  property p_sum3_single;
    power_update && (pulse_include[8:6] == 3'b100) &&
      (pulse_type[8:6] == 3'b011) |=>
      (sign[8] == $past(phase_power[2].fund_act[23]));
  endproperty
  a_sum3_single: assert property (p_sum3_single)
    else $error("datapath three sum sign wrong");

  property p_sum_pair;
    power_update && (pulse_include[2:0] == 3'b011) &&
      (pulse_type[2:0] == 3'b001) &&
      (phase_power[0].tot_react[23] == phase_power[1].tot_react[23]) |=>
      (sign[3] == $past(phase_power[0].tot_react[23]));
  endproperty
  a_sum_pair: assert property (p_sum_pair)
    else $error("same-sign pair sum has wrong sign");

  property p_sign_reserved;
    rd_sign |=> (hrdata[31:9] == 23'h000000) && hreadyout;
  endproperty
  a_sign_reserved: assert property (p_sign_reserved)
    else $error("sign status reserved bits not zero");

  property p_type_reserved;
    (pulse_type[5:3] > 3'b100) |=> !pulse_type_valid[1];
  endproperty
  a_type_reserved: assert property (p_type_reserved)
    else $error("reserved power type left output enabled");

  property p_sign_hold;
    !power_update |=> $stable(sign);
  endproperty
  a_sign_hold: assert property (p_sign_hold)
    else $error("sign status changed without a new sample");

endmodule

// ### dv/pcps_regs_bench.sv
// Purpose: self-checking bench for the compensation and sign registers
// Assumes: single AHB-Lite slave, hready taken back from hreadyout
// Notes: expected values are rebuilt here from the field encodings
`timescale 1ns/1ps
module pcps_regs_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic power_update = 1'b0;
  pcps_pkg::pcps_phase_power_s [2:0] phase_power = '0;
  logic [2:0] comp_voltage_sel;
  logic [2:0][pcps_pkg::COMP_AMT_W-1:0] comp_amount;
  logic [2:0] pulse_type_valid;
  logic irq;
  logic [31:0] rd_s;
  logic rdy_s;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  pcps_regs pcps_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .power_update(power_update), .phase_power(phase_power),
    .comp_voltage_sel(comp_voltage_sel), .comp_amount(comp_amount),
    .pulse_type_valid(pulse_type_valid), .irq(irq)
  );

  initial begin
    forever #20 hclk = ~hclk;
  end

  // Edge snapshots, so a sample never races the register update
  always @(posedge hclk) begin
    rd_s <= hrdata;
    rdy_s <= hreadyout;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      end_sim();
    end
  end

  task automatic tick();
    @(posedge hclk);
    #1;
  endtask

  task automatic ahb_req(input logic [15:0] idx, input logic wr,
                         input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= pcps_pkg::HSIZE_WORD;
    haddr <= {14'h0, idx, 2'h0};
    tick();
    while (rdy_s !== 1'b1) tick();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    tick();
    while (rdy_s !== 1'b1) tick();
    q = rd_s;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    ahb_req(idx, 1'b1, d, q);
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic [11:0] e,
                         input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input string n, input logic [15:0] idx,
                        input logic [31:0] e);
    logic [31:0] q;
    ahb_req(idx, 1'b0, 32'h0, q);
    chk_reg(n, e, q);
    chk_pin("hresp", 12'h0, {11'h0, hresp});
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) tick();
    hresetn <= 1'b1;
    tick();
  endtask

  task automatic pulse(input pcps_pkg::pcps_phase_power_s [2:0] p);
    phase_power <= p;
    power_update <= 1'b1;
    tick();
    power_update <= 1'b0;
    tick();
  endtask

  function automatic pcps_pkg::pcps_phase_power_s mk(int ta, int fa,
                                                     int tr, int fr, int ap);
    return '{ta[23:0], fa[23:0], tr[23:0], fr[23:0], ap[23:0]};
  endfunction

  function automatic logic [8:0] exp_sign(input logic [1:0] src,
    input logic [8:0] inc, input logic [8:0] typ,
    input pcps_pkg::pcps_phase_power_s [2:0] p);
    logic [8:0] s;
    logic signed [25:0] sum;
    logic signed [23:0] v;
    logic [2:0] t;
    s = 9'h000;
    for (int k = 0; k < 3; k++) begin
      s[k] = src[0] ? p[k].fund_act[23] : p[k].tot_act[23];
      s[k + 4] = src[1] ? p[k].fund_react[23] : p[k].tot_react[23];
    end
    for (int d = 0; d < 3; d++) begin
      t = typ[3 * d +: 3];
      sum = '0;
      for (int k = 0; k < 3; k++) begin
        case (t)
          3'h0: v = p[k].tot_act;
          3'h1: v = p[k].tot_react;
          3'h2: v = p[k].apparent;
          3'h3: v = p[k].fund_act;
          3'h4: v = p[k].fund_react;
          default: v = '0;
        endcase
        if (inc[3 * d + k]) sum = sum + v;
      end
      s[(d == 0) ? 3 : d + 6] = sum[25];
    end
    return s;
  endfunction

  task automatic t_reset();
    rd_chk("phase_a_phase_comp", pcps_pkg::IDX_PHASE_A_COMP, 32'h0);
    rd_chk("phase_b_phase_comp", pcps_pkg::IDX_PHASE_B_COMP, 32'h0);
    rd_chk("phase_c_phase_comp", pcps_pkg::IDX_PHASE_C_COMP, 32'h0);
    rd_chk("power_sign_status", pcps_pkg::IDX_SIGN_STATUS, 32'h0);
    rd_chk("sign_source", pcps_pkg::IDX_SIGN_SOURCE, 32'h0);
    rd_chk("pulse_include", pcps_pkg::IDX_PULSE_INCLUDE, 32'h1FF);
    rd_chk("pulse_type", pcps_pkg::IDX_PULSE_TYPE, 32'h088);
    rd_chk("irq_enable", pcps_pkg::IDX_IRQ_ENABLE, 32'h0);
    chk_pin("pulse_type_valid", 12'h7, {9'h0, pulse_type_valid});
    chk_pin("irq", 12'h0, {11'h0, irq});
  endtask

  // Codes at each end of every range, aliases included
  task automatic t_comp();
    logic [9:0] cc [8] = '{10'h000, 10'h17F, 10'h180, 10'h1FF,
                           10'h200, 10'h37F, 10'h380, 10'h3FF};
    logic [9:0] ev [8] = '{10'h000, 10'h17F, 10'h000, 10'h07F,
                           10'h200, 10'h37F, 10'h200, 10'h27F};
    logic [15:0] idx;
    int ph;
    for (int i = 0; i < 8; i++) begin
      ph = i % 3;
      idx = pcps_pkg::IDX_PHASE_A_COMP + 16'(ph);
      wr(idx, {22'h3FFFFF, cc[i]});
      tick();
      chk_pin("comp_decode", {2'h0, ev[i]},
              {2'h0, comp_voltage_sel[ph], comp_amount[ph]});
      rd_chk("phase_comp", idx, {22'h0, cc[i]});
    end
    do_reset();
    rd_chk("phase_a_phase_comp", pcps_pkg::IDX_PHASE_A_COMP, 32'h0);
    rd_chk("phase_b_phase_comp", pcps_pkg::IDX_PHASE_B_COMP, 32'h0);
    rd_chk("phase_c_phase_comp", pcps_pkg::IDX_PHASE_C_COMP, 32'h0);
    chk_pin("comp_outputs", 12'h0,
            {comp_voltage_sel, comp_amount[0]} | comp_amount[2]);
  endtask

  // Extreme set needs the wide sum: a 24-bit adder would wrap
  task automatic t_sign();
    pcps_pkg::pcps_phase_power_s [2:0] p;
    logic [8:0] inc [3] = '{9'h173, 9'h1FF, 9'h102};
    logic [8:0] typ;
    logic [8:0] es;
    logic [1:0] src;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 3; k++) begin
        p[k] = mk(-8388608, 8388607, -8388608, 8388607, 8388607);
      end
      if (s == 0) begin
        p[0] = mk(-100, 50, 30, -70, 5);
        p[1] = mk(120, -90, -40, 90, -200);
        p[2] = mk(-30, -10, 15, -60, 100);
      end
      for (int c = 0; c < 3; c++) begin
        for (int t = 0; t < 8; t++) begin
          typ = {3'(t + 2), 3'(t + 1), 3'(t)};
          src = 2'(t + c);
          wr(pcps_pkg::IDX_SIGN_SOURCE, {30'h0, src});
          wr(pcps_pkg::IDX_PULSE_INCLUDE, {23'h0, inc[c]});
          wr(pcps_pkg::IDX_PULSE_TYPE, {23'h0, typ});
          tick();
          chk_pin("pulse_type_valid", {9'h0, typ[8:6] <= 3'h4,
                  typ[5:3] <= 3'h4, typ[2:0] <= 3'h4},
                  {9'h0, pulse_type_valid});
          pulse(p);
          es = exp_sign(src, inc[c], typ, p);
          rd_chk("power_sign_status", pcps_pkg::IDX_SIGN_STATUS,
                 {23'h0, es});
        end
      end
    end
    wr(pcps_pkg::IDX_SIGN_STATUS, 32'hFFFFFFFF);
    rd_chk("power_sign_status", pcps_pkg::IDX_SIGN_STATUS, {23'h0, es});
    wr(16'hE618, 32'hFFFFFFFF);
    rd_chk("unmapped", 16'hE618, 32'h0);
    do_reset();
    rd_chk("power_sign_status", pcps_pkg::IDX_SIGN_STATUS, 32'h0);
  endtask

  task automatic t_irq();
    pcps_pkg::pcps_phase_power_s [2:0] z;
    pcps_pkg::pcps_phase_power_s [2:0] p;
    z = '0;
    p = '0;
    p[0] = mk(-5, 0, 0, 0, 0);
    wr(pcps_pkg::IDX_PULSE_INCLUDE, 32'h0);
    wr(pcps_pkg::IDX_SIGN_SOURCE, 32'h0);
    wr(pcps_pkg::IDX_IRQ_ENABLE, 32'h0);
    pulse(z);
    wr(pcps_pkg::IDX_IRQ_CLEAR, 32'h1FF);
    rd_chk("irq_status", pcps_pkg::IDX_IRQ_STATUS, 32'h0);
    pulse(p);
    rd_chk("irq_status", pcps_pkg::IDX_IRQ_STATUS, 32'h1);
    chk_pin("irq_masked", 12'h0, {11'h0, irq});
    wr(pcps_pkg::IDX_IRQ_ENABLE, 32'h1);
    tick();
    chk_pin("irq_enabled", 12'h1, {11'h0, irq});
    wr(pcps_pkg::IDX_IRQ_CLEAR, 32'h1);
    tick();
    chk_pin("irq_cleared", 12'h0, {11'h0, irq});
    pulse(p);
    chk_pin("irq_no_change", 12'h0, {11'h0, irq});
    pulse(z);
    chk_pin("irq_change", 12'h1, {11'h0, irq});
    wr(pcps_pkg::IDX_IRQ_STATUS, 32'h0);
    rd_chk("irq_status", pcps_pkg::IDX_IRQ_STATUS, 32'h1);
    wr(pcps_pkg::IDX_IRQ_CLEAR, 32'h1FF);
    tick();
    chk_pin("irq_final", 12'h0, {11'h0, irq});
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_reset();
    t_comp();
    t_sign();
    t_irq();
    end_sim();
  end
endmodule
